// ===== logic/pin_ctrl_pkg.sv
// Shared constants and types for the reset, mode and pin-sharing block
package pin_ctrl_pkg;
  localparam int PIN_COUNT = 8;
  localparam logic [PIN_COUNT-1:0] KEYPAD_PIN_MASK = 8'hF0;
  // Bus and self clock rates
  localparam int CLK_HZ = 250_000_000;
  localparam int SELF_CLK_HZ = 8_000_000;
  localparam int SELF_DIV = CLK_HZ / SELF_CLK_HZ;
  localparam logic [5:0] SELF_DIV_LAST = 6'(SELF_DIV - 1);
  // Reset pin sequence, in self clock cycles
  localparam logic [5:0] RST_DRIVE_CYCLES = 6'd34;
  localparam logic [5:0] RST_WAIT_CYCLES = 6'd38;
  // Debug link bit cell, in debug clock cycles
  localparam logic [4:0] DBG_BIT_CYCLES = 5'd16;
  localparam logic [4:0] DBG_ONE_LOW = 5'd4;
  localparam logic [4:0] DBG_ZERO_LOW = 5'd13;
  localparam logic [4:0] DBG_SAMPLE_AT = 5'd10;
  // Register byte addresses
  localparam logic [7:0] ADDR_PORT_DATA = 8'h00;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h04;
  localparam logic [7:0] ADDR_PORT_PULL = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'h10;
  localparam logic [7:0] ADDR_DEBUG_CTRL = 8'h14;
  // Interrupt pin control fields
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_RISE_BIT = 1;
  localparam int IRQ_TMR_BIT = 2;
  localparam int IRQ_PULL_BIT = 3;
  localparam logic [3:0] IRQ_CTRL_RESET = 4'h0;
  // Reset cause fields
  localparam int CAUSE_POR_BIT = 0;
  localparam int CAUSE_PIN_BIT = 1;
  localparam int CAUSE_WDOG_BIT = 2;
  localparam int CAUSE_LVD_BIT = 3;
  localparam int CAUSE_ILOP_BIT = 4;
  localparam logic [4:0] CAUSE_POR_VALUE = 5'h01;
  localparam logic [7:0] DBG_DIV_RESET = 8'h00;

  typedef struct packed {
    logic [PIN_COUNT-1:0] en;
    logic [PIN_COUNT-1:0] oe;
    logic [PIN_COUNT-1:0] out;
  } alt_drive_t;

  typedef struct packed {
    logic pin_in;
    logic pin_out;
    logic pin_oe;
  } pin_io_t;

  typedef enum logic [1:0] {RST_DRIVE, RST_WAIT, RST_HOLD_EXT, RST_RUN} rst_state_t;
endpackage

// ===== logic/reset_mode_pin_sharing.sv
// Reset pin sequencer, mode pin and debug link, interrupt pin, shared port pins
`timescale 1ns/1ps
`default_nettype none
module reset_mode_pin_sharing
  import pin_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic wdog_reset_req,
  input wire logic lvd_reset_req,
  input wire logic ilop_reset_req,
  output logic system_reset_n,
  output logic background_mode,
  input wire pin_io_t debug_mode_select_pin,
  output logic debug_pin_pullup,
  output logic debug_pin_out,
  output logic debug_pin_oe,
  input wire logic dbg_tx_valid,
  input wire logic dbg_tx_bit,
  output logic dbg_busy,
  output logic dbg_rx_valid,
  output logic dbg_rx_bit,
  input wire logic irq_pin_in,
  output logic irq_pin_pullup,
  output logic irq_pin_pulldown,
  output logic irq_request,
  output logic branch_if_int_pin_high,
  output logic timer_external_clock_input,
  input wire alt_drive_t alt1,
  input wire alt_drive_t alt2,
  input wire logic [PIN_COUNT-1:0] keypad_rising_sens,
  input wire logic [PIN_COUNT-1:0] port_pin_in,
  output logic [PIN_COUNT-1:0] port_pin_out,
  output logic [PIN_COUNT-1:0] port_pin_oe,
  output logic [PIN_COUNT-1:0] port_pin_pullup,
  output logic [PIN_COUNT-1:0] port_pin_pulldown,
  output logic [PIN_COUNT-1:0] alt_pin_in
);
  // Synchronisers: first stage read only by second stage
  logic [PIN_COUNT+2:0] sync1;
  logic [PIN_COUNT+2:0] sync2;
  logic rst_pin_s;
  logic dbg_pin_s;
  logic irq_pin_s;
  logic [PIN_COUNT-1:0] port_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '1;
      sync2 <= '1;
    end else if (clk_en) begin
      sync1 <= {reset_pin_in, debug_mode_select_pin.pin_in, irq_pin_in, port_pin_in};
      sync2 <= sync1;
    end
  end
  assign {rst_pin_s, dbg_pin_s, irq_pin_s, port_s} = sync2;

  // Self clock tick, about 8 MHz, used while reset sequences
  logic [5:0] self_div;
  logic self_tick;
  assign self_tick = (self_div == SELF_DIV_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      self_div <= '0;
    end else if (clk_en) begin
      self_div <= self_tick ? 6'h00 : self_div + 6'h01;
    end
  end

  // Reset sequencer
  rst_state_t rst_state;
  logic [5:0] rst_cnt;
  logic [4:0] reset_cause_status_register;
  logic internal_req;
  logic in_reset;
  assign internal_req = wdog_reset_req | lvd_reset_req | ilop_reset_req;
  assign in_reset = (rst_state != RST_RUN);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_state <= RST_DRIVE;
      rst_cnt <= '0;
    end else if (clk_en) begin
      case (rst_state)
        RST_RUN: begin
          if (internal_req || !rst_pin_s) begin
            rst_state <= RST_DRIVE;
            rst_cnt <= '0;
          end
        end
        RST_DRIVE: begin
          if (self_tick) begin
            if (rst_cnt == RST_DRIVE_CYCLES - 6'd1) begin
              rst_state <= RST_WAIT;
              rst_cnt <= '0;
            end else begin
              rst_cnt <= rst_cnt + 6'd1;
            end
          end
        end
        RST_WAIT: begin
          if (self_tick) begin
            if (rst_cnt == RST_WAIT_CYCLES - 6'd1) begin
              rst_cnt <= '0;
              // Pin still low means someone outside holds it
              rst_state <= rst_pin_s ? RST_RUN : RST_HOLD_EXT;
            end else begin
              rst_cnt <= rst_cnt + 6'd1;
            end
          end
        end
        RST_HOLD_EXT: begin
          if (rst_pin_s) begin
            rst_state <= RST_RUN;
          end
        end
        default: begin
          rst_state <= RST_DRIVE;
        end
      endcase
    end
  end

  // Cause bits replaced at each new reset; pin bit added when held outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_cause_status_register <= CAUSE_POR_VALUE;
    end else if (clk_en) begin
      if (rst_state == RST_RUN && (internal_req || !rst_pin_s)) begin
        reset_cause_status_register <= '0;
        reset_cause_status_register[CAUSE_WDOG_BIT] <= wdog_reset_req;
        reset_cause_status_register[CAUSE_LVD_BIT] <= lvd_reset_req;
        reset_cause_status_register[CAUSE_ILOP_BIT] <= ilop_reset_req;
        reset_cause_status_register[CAUSE_PIN_BIT] <= !internal_req;
      end else if (rst_state == RST_WAIT && self_tick && rst_cnt == RST_WAIT_CYCLES - 6'd1
                   && !rst_pin_s) begin
        reset_cause_status_register[CAUSE_PIN_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b0;
      system_reset_n <= 1'b0;
    end else if (clk_en) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= (rst_state == RST_DRIVE);
      system_reset_n <= !in_reset;
    end
  end

  // Mode select caught as reset rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      background_mode <= 1'b0;
    end else if (clk_en) begin
      if (in_reset && system_reset_n == 1'b0 && rst_state != RST_DRIVE
          && rst_pin_s && (rst_state == RST_HOLD_EXT
          || (self_tick && rst_cnt == RST_WAIT_CYCLES - 6'd1))) begin
        background_mode <= !dbg_pin_s;
      end
    end
  end

  // Debug link bit engine; debug clock derived from bus clock
  logic [7:0] dbg_div;
  logic [7:0] dbg_div_cnt;
  logic dbg_tick;
  logic [4:0] dbg_cnt;
  logic [4:0] dbg_low_len;
  logic dbg_driving;
  logic dbg_prev;
  assign dbg_tick = (dbg_div_cnt == dbg_div);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_div_cnt <= '0;
    end else if (clk_en) begin
      dbg_div_cnt <= (dbg_tick || !dbg_busy) ? 8'h00 : dbg_div_cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_busy <= 1'b0;
      dbg_cnt <= '0;
      dbg_low_len <= '0;
      dbg_driving <= 1'b0;
      dbg_prev <= 1'b1;
      dbg_rx_valid <= 1'b0;
      dbg_rx_bit <= 1'b0;
    end else if (clk_en) begin
      dbg_prev <= dbg_pin_s;
      dbg_rx_valid <= 1'b0;
      if (in_reset) begin
        dbg_busy <= 1'b0;
        dbg_driving <= 1'b0;
      end else if (!dbg_busy) begin
        if (dbg_tx_valid) begin
          dbg_busy <= 1'b1;
          dbg_driving <= 1'b1;
          dbg_cnt <= '0;
          dbg_low_len <= dbg_tx_bit ? DBG_ONE_LOW : DBG_ZERO_LOW;
        end else if (dbg_prev && !dbg_pin_s) begin
          // Host started a cell; we only listen
          dbg_busy <= 1'b1;
          dbg_driving <= 1'b0;
          dbg_cnt <= 5'd2;
        end
      end else if (dbg_tick) begin
        if (dbg_cnt == DBG_SAMPLE_AT - 5'd1) begin
          dbg_rx_bit <= dbg_pin_s;
        end
        if (dbg_cnt == DBG_BIT_CYCLES - 5'd1) begin
          dbg_busy <= 1'b0;
          dbg_driving <= 1'b0;
          dbg_rx_valid <= 1'b1;
        end else begin
          dbg_cnt <= dbg_cnt + 5'd1;
        end
      end
    end
  end

  // Pin drive: low phase, one speedup cycle high, then released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_pin_pullup <= 1'b1;
    end else if (clk_en) begin
      debug_pin_pullup <= 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_pin_oe <= 1'b0;
      debug_pin_out <= 1'b0;
    end else if (clk_en) begin
      // Input only while in reset
      debug_pin_oe <= !in_reset && dbg_driving && dbg_busy
                      && dbg_cnt <= dbg_low_len;
      debug_pin_out <= (dbg_cnt == dbg_low_len);
    end
  end

  // Interrupt pin
  logic [3:0] irq_ctrl;
  logic irq_prev;
  logic irq_en;
  logic irq_rise;
  assign irq_en = irq_ctrl[IRQ_EN_BIT];
  assign irq_rise = irq_ctrl[IRQ_RISE_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_prev <= 1'b1;
      irq_request <= 1'b0;
      branch_if_int_pin_high <= 1'b1;
      timer_external_clock_input <= 1'b0;
      irq_pin_pullup <= 1'b0;
      irq_pin_pulldown <= 1'b0;
    end else if (clk_en) begin
      irq_prev <= irq_pin_s;
      irq_request <= irq_en && (irq_rise ? (!irq_prev && irq_pin_s)
                                         : (irq_prev && !irq_pin_s));
      branch_if_int_pin_high <= irq_pin_s;
      timer_external_clock_input <= !irq_en && irq_ctrl[IRQ_TMR_BIT] && irq_pin_s;
      irq_pin_pullup <= irq_ctrl[IRQ_PULL_BIT] && !(irq_en && irq_rise);
      irq_pin_pulldown <= irq_ctrl[IRQ_PULL_BIT] && irq_en && irq_rise;
    end
  end

  // Shared port pins
  logic [PIN_COUNT-1:0] port_data;
  logic [PIN_COUNT-1:0] port_dir;
  logic [PIN_COUNT-1:0] port_pull;
  logic [PIN_COUNT-1:0] next_oe;
  logic [PIN_COUNT-1:0] next_out;
  logic [PIN_COUNT-1:0] pull_down_sel;
  always_comb begin
    // Alternate two beats alternate one beats the port
    next_oe = (alt2.en & alt2.oe) | (~alt2.en & alt1.en & alt1.oe)
            | (~alt2.en & ~alt1.en & port_dir);
    next_out = (alt2.en & alt2.out) | (~alt2.en & alt1.en & alt1.out)
             | (~alt2.en & ~alt1.en & port_data);
    pull_down_sel = KEYPAD_PIN_MASK & alt1.en & ~alt2.en & keypad_rising_sens;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_pin_out <= '0;
      port_pin_oe <= '0;
      port_pin_pullup <= '0;
      port_pin_pulldown <= '0;
      alt_pin_in <= '0;
    end else if (clk_en) begin
      port_pin_out <= next_out;
      port_pin_oe <= in_reset ? '0 : next_oe;
      port_pin_pullup <= in_reset ? '0 : port_pull & ~next_oe & ~pull_down_sel;
      port_pin_pulldown <= in_reset ? '0 : port_pull & ~next_oe & pull_down_sel;
      alt_pin_in <= port_s;
    end
  end

  // APB slave: one wait state, answer registered
  logic acc;
  logic wr_done;
  logic [31:0] next_rdata;
  logic next_err;
  assign acc = psel && penable && !pready;
  assign wr_done = psel && penable && pready && pwrite && !pslverr;
  always_comb begin
    next_rdata = '0;
    next_err = 1'b0;
    case (paddr)
      // Direction picks latch or pin for port reads
      ADDR_PORT_DATA: next_rdata[PIN_COUNT-1:0] = (port_dir & port_data)
                                                  | (~port_dir & port_s);
      ADDR_PORT_DIR: next_rdata[PIN_COUNT-1:0] = port_dir;
      ADDR_PORT_PULL: next_rdata[PIN_COUNT-1:0] = port_pull;
      ADDR_IRQ_CTRL: next_rdata[3:0] = irq_ctrl;
      ADDR_RESET_CAUSE: next_rdata[4:0] = reset_cause_status_register;
      ADDR_DEBUG_CTRL: next_rdata[9:0] = {background_mode, dbg_busy, dbg_div};
      default: next_err = 1'b1;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= acc;
      pslverr <= acc && next_err;
      prdata <= (acc && !pwrite) ? next_rdata : '0;
    end
  end

  // Every reset returns port and interrupt pins to plain inputs without pulls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data <= '0;
      port_dir <= '0;
      port_pull <= '0;
      irq_ctrl <= IRQ_CTRL_RESET;
      dbg_div <= DBG_DIV_RESET;
    end else if (clk_en) begin
      if (in_reset) begin
        port_dir <= '0;
        port_pull <= '0;
        irq_ctrl <= IRQ_CTRL_RESET;
        dbg_div <= DBG_DIV_RESET;
      end else if (wr_done) begin
        case (paddr)
          ADDR_PORT_DATA: port_data <= pwdata[PIN_COUNT-1:0];
          ADDR_PORT_DIR: port_dir <= pwdata[PIN_COUNT-1:0];
          ADDR_PORT_PULL: port_pull <= pwdata[PIN_COUNT-1:0];
          ADDR_IRQ_CTRL: irq_ctrl <= pwdata[3:0];
          ADDR_DEBUG_CTRL: dbg_div <= pwdata[7:0];
          default: port_data <= port_data;
        endcase
      end
    end
  end

  // Drive fields of the mode pin carrier are not read
  logic debug_mode_select_pin_unused;
  assign debug_mode_select_pin_unused = debug_mode_select_pin.pin_out ^ debug_mode_select_pin.pin_oe;
endmodule
`default_nettype wire

// ===== testbench/board_pod.sv
// Board reset circuit and debug pod model
`timescale 1ns/1ps
`default_nettype none
module board_pod
  import pin_ctrl_pkg::*;
(
  input wire logic reset_pin_oe,
  input wire logic reset_pin_out,
  input wire logic ext_hold,
  input wire logic pod_low,
  input wire logic dbg_oe,
  input wire logic dbg_out,
  output logic reset_pin_in,
  output var pin_io_t mode_pin
);
  // Pullup wins unless some party pulls low
  assign reset_pin_in = !(reset_pin_oe && !reset_pin_out) && !ext_hold;
  // Either side only pulls low or pulses high; release lets the pullup restore high
  assign mode_pin = '{pin_in: !pod_low && !(dbg_oe && !dbg_out),
                      pin_out: 1'b0, pin_oe: pod_low};
endmodule
`default_nettype wire

// ===== testbench/pin_ctrl_props.sv
// Assertion checker for the reset, mode and pin-sharing block
`timescale 1ns/1ps
`default_nettype none
module pin_ctrl_props
  import pin_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic wdog_reset_req,
  input wire logic system_reset_n,
  input wire logic background_mode,
  input wire pin_io_t debug_mode_select_pin,
  input wire logic debug_pin_pullup,
  input wire logic debug_pin_oe,
  input wire logic dbg_busy,
  input wire alt_drive_t alt2,
  input wire logic [PIN_COUNT-1:0] port_pin_oe,
  input wire logic [PIN_COUNT-1:0] port_pin_out,
  input wire logic [PIN_COUNT-1:0] port_pin_pullup
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_drive_is_low: assert property (reset_pin_oe |-> !reset_pin_out)
    else $error("reset pin driven high");
  a_drive_in_reset: assert property (reset_pin_oe |-> !system_reset_n)
    else $error("reset pin driven while running");
  a_internal_req: assert property (system_reset_n && wdog_reset_req |-> ##[1:3] reset_pin_oe)
    else $error("internal request did not drive the reset pin");
  a_ext_pin_entry: assert property (system_reset_n && !reset_pin_in ##1 !reset_pin_in
    |-> ##[0:5] !system_reset_n) else $error("pin pulled low did not reset");
  a_rise_pin_high: assert property ($rose(system_reset_n) |-> $past(reset_pin_in))
    else $error("left reset with the pin low");
  a_mode_pullup: assert property (!system_reset_n |-> debug_pin_pullup)
    else $error("mode pin pullup off in reset");
  a_mode_no_drive: assert property (!system_reset_n |-> !debug_pin_oe)
    else $error("mode pin driven in reset");
  a_mode_latch: assert property ($rose(system_reset_n)
    |-> background_mode == !$past(debug_mode_select_pin.pin_in)) else $error("wrong mode");
  a_pins_idle: assert property ($rose(system_reset_n) && alt2.en == '0
    |-> port_pin_pullup == '0) else $error("pins not idle after reset");
  a_alt2_owns: assert property (system_reset_n && $stable(alt2) ##1 $stable(alt2)
    |-> ((port_pin_oe ^ alt2.oe) & alt2.en) == '0 && ((port_pin_out ^ alt2.out) & alt2.en) == '0)
    else $error("second alternate lost the pin");
  c_background_mode: cover property ($rose(system_reset_n) && background_mode);
  c_cell: cover property ($fell(dbg_busy));
  c_held: cover property (!system_reset_n && !reset_pin_oe && !reset_pin_in);
endmodule
bind reset_mode_pin_sharing pin_ctrl_props u_props (.pclk(pclk), .presetn(presetn),
  .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
  .wdog_reset_req(wdog_reset_req), .system_reset_n(system_reset_n),
  .background_mode(background_mode), .debug_mode_select_pin(debug_mode_select_pin),
  .debug_pin_pullup(debug_pin_pullup), .debug_pin_oe(debug_pin_oe),
  .dbg_busy(dbg_busy), .alt2(alt2),
  .port_pin_oe(port_pin_oe), .port_pin_out(port_pin_out), .port_pin_pullup(port_pin_pullup));
`default_nettype wire

// ===== testbench/reset_mode_pin_sharing_test.sv
// Self-checking bench for the reset, mode and pin-sharing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module reset_mode_pin_sharing_test;
  import pin_ctrl_pkg::*;
  localparam int DRV = int'(RST_DRIVE_CYCLES) * SELF_DIV;
  localparam int WT = int'(RST_WAIT_CYCLES) * SELF_DIV;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dbg_tx_valid, dbg_tx_bit, err;
  logic reset_pin_in, reset_pin_out, reset_pin_oe, wdog_reset_req, lvd_reset_req, ilop_reset_req;
  logic system_reset_n, background_mode, debug_pin_pullup, dbg_busy, dbg_rx_valid, dbg_rx_bit;
  logic irq_pin_in, irq_pin_pullup, irq_pin_pulldown, irq_request, irq_high, tmr_clk;
  logic ext_hold, pod_low, debug_pin_out, debug_pin_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [PIN_COUNT-1:0] keypad_rising_sens, port_pin_in, port_pin_out, port_pin_oe;
  logic [PIN_COUNT-1:0] port_pin_pullup, port_pin_pulldown, alt_pin_in;
  pin_io_t mode_pin;
  alt_drive_t alt1, alt2;
  int num_errors;
  int n_checks;
  reset_mode_pin_sharing dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .wdog_reset_req(wdog_reset_req),
    .lvd_reset_req(lvd_reset_req), .ilop_reset_req(ilop_reset_req),
    .system_reset_n(system_reset_n), .background_mode(background_mode),
    .debug_mode_select_pin(mode_pin), .debug_pin_pullup(debug_pin_pullup),
    .debug_pin_out(debug_pin_out), .debug_pin_oe(debug_pin_oe),
    .dbg_tx_valid(dbg_tx_valid), .dbg_tx_bit(dbg_tx_bit), .dbg_busy(dbg_busy),
    .dbg_rx_valid(dbg_rx_valid), .dbg_rx_bit(dbg_rx_bit), .irq_pin_in(irq_pin_in),
    .irq_pin_pullup(irq_pin_pullup), .irq_pin_pulldown(irq_pin_pulldown),
    .irq_request(irq_request), .branch_if_int_pin_high(irq_high),
    .timer_external_clock_input(tmr_clk), .alt1(alt1), .alt2(alt2),
    .keypad_rising_sens(keypad_rising_sens), .port_pin_in(port_pin_in),
    .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .port_pin_pullup(port_pin_pullup),
    .port_pin_pulldown(port_pin_pulldown), .alt_pin_in(alt_pin_in));
  board_pod pod (.reset_pin_oe(reset_pin_oe), .reset_pin_out(reset_pin_out),
    .dbg_oe(debug_pin_oe), .dbg_out(debug_pin_out),
    .ext_hold(ext_hold), .pod_low(pod_low), .reset_pin_in(reset_pin_in), .mode_pin(mode_pin));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task results;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Drive length and the wait up to the return to run
  task chk_seq;
    int n, drv, gap;
    n = 0;
    while (reset_pin_oe !== 1'b1 && n < 50) begin @(posedge pclk); n++; end
    drv = 0;
    while (reset_pin_oe === 1'b1 && drv < 3000) begin @(posedge pclk); drv++; end
    gap = 0;
    while (system_reset_n !== 1'b1 && gap < 3000) begin @(posedge pclk); gap++; end
    `CHK(drv inside {[DRV-SELF_DIV:DRV+SELF_DIV]}, 1'b1)
    `CHK(gap inside {[WT-SELF_DIV:WT+SELF_DIV+8]}, 1'b1)
  endtask
  task t_power_on;
    chk_seq();
    `CHK(background_mode, 1'b1)
    `CHK(debug_pin_pullup, 1'b1)
    `CHK(port_pin_oe, 8'h00)
    `CHK(port_pin_pullup, 8'h00)
    apb(1'b0, ADDR_RESET_CAUSE, 32'h0);
    `CHK(rd, 32'(CAUSE_POR_VALUE))
    pod_low <= 1'b0;
    $display("test power_on done");
  endtask
  task t_internal;
    int bits[3] = '{CAUSE_WDOG_BIT, CAUSE_LVD_BIT, CAUSE_ILOP_BIT};
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      wdog_reset_req <= (i == 0);
      lvd_reset_req <= (i == 1);
      ilop_reset_req <= (i == 2);
      cyc(2);
      {wdog_reset_req, lvd_reset_req, ilop_reset_req} <= 3'h0;
      chk_seq();
      `CHK(background_mode, 1'b0)
      apb(1'b0, ADDR_RESET_CAUSE, 32'h0);
      `CHK(rd, 32'h1 << bits[i])
    end
    $display("test internal done");
  endtask
  // Internal reset with the board still holding the pin low
  task t_held;
    int n;
    @(posedge pclk);
    lvd_reset_req <= 1'b1;
    cyc(2);
    lvd_reset_req <= 1'b0;
    ext_hold <= 1'b1;
    cyc(DRV + WT + 300);
    `CHK(system_reset_n, 1'b0)
    ext_hold <= 1'b0;
    // Held reset ends without a new drive phase
    n = 0;
    while (system_reset_n !== 1'b1 && n < 20) begin @(posedge pclk); n++; end
    `CHK(system_reset_n, 1'b1)
    `CHK(reset_pin_oe, 1'b0)
    `CHK(background_mode, 1'b0)
    apb(1'b0, ADDR_RESET_CAUSE, 32'h0);
    `CHK(rd, (32'h1 << CAUSE_LVD_BIT) | (32'h1 << CAUSE_PIN_BIT))
    $display("test held done");
  endtask
  task t_external;
    @(posedge pclk);
    ext_hold <= 1'b1;
    cyc(8);
    `CHK(system_reset_n, 1'b0)
    ext_hold <= 1'b0;
    chk_seq();
    apb(1'b0, ADDR_RESET_CAUSE, 32'h0);
    `CHK(rd, 32'h1 << CAUSE_PIN_BIT)
    $display("test external done");
  endtask
  task t_pins;
    port_pin_in <= 8'h5A;
    apb(1'b1, ADDR_PORT_DIR, 32'h01);
    apb(1'b1, ADDR_PORT_DATA, 32'h01);
    apb(1'b1, ADDR_PORT_PULL, 32'hF2);
    cyc(3);
    `CHK(port_pin_oe[0], 1'b1)
    `CHK(port_pin_out[0], 1'b1)
    alt1 <= '{en: 8'h13, oe: 8'h01, out: 8'h00};
    keypad_rising_sens <= 8'h10;
    cyc(3);
    `CHK(port_pin_out[0], 1'b0)
    `CHK(port_pin_pullup[1], 1'b1)
    `CHK(port_pin_pullup[5], 1'b1)
    `CHK(port_pin_pulldown[4], 1'b1)
    `CHK(port_pin_pullup[4], 1'b0)
    alt2 <= '{en: 8'h01, oe: 8'h01, out: 8'h01};
    cyc(3);
    `CHK(port_pin_out[0], 1'b1)
    apb(1'b0, ADDR_PORT_DATA, 32'h0);
    `CHK(rd, 32'h0000005B)
    apb(1'b1, ADDR_PORT_DIR, 32'h00);
    cyc(3);
    apb(1'b0, ADDR_PORT_DATA, 32'h0);
    `CHK(rd, 32'h0000005A)
    `CHK(alt_pin_in, 8'h5A)
    `CHK(port_pin_oe[0], 1'b1)
    apb(1'b0, 8'h18, 32'h0);
    `CHK(err, 1'b1)
    alt1 <= '0;
    alt2 <= '0;
    $display("test pins done");
  endtask
  task t_irq;
    int n;
    apb(1'b1, ADDR_IRQ_CTRL, 32'h0B);
    cyc(2);
    `CHK(irq_pin_pulldown, 1'b1)
    `CHK(irq_pin_pullup, 1'b0)
    irq_pin_in <= 1'b1;
    n = 0;
    repeat (8) begin @(posedge pclk); n += int'(irq_request === 1'b1); end
    `CHK(n, 1)
    `CHK(irq_high, 1'b1)
    apb(1'b1, ADDR_IRQ_CTRL, 32'h0C);
    irq_pin_in <= 1'b0;
    cyc(4);
    `CHK(tmr_clk, 1'b0)
    `CHK(irq_pin_pullup, 1'b1)
    irq_pin_in <= 1'b1;
    cyc(4);
    `CHK(tmr_clk, 1'b1)
    apb(1'b1, ADDR_IRQ_CTRL, 32'h09);
    irq_pin_in <= 1'b0;
    n = 0;
    repeat (8) begin @(posedge pclk); n += int'(irq_request === 1'b1); end
    `CHK(n, 1)
    `CHK(irq_pin_pullup, 1'b1)
    $display("test irq done");
  endtask
  // Divider 0 then 1: cell length follows the debug clock
  task t_debug;
    int n, n_low, n_hi;
    logic got_v, got_b;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, ADDR_DEBUG_CTRL, 32'(i));
      dbg_tx_valid <= 1'b1;
      dbg_tx_bit <= (i == 0);
      pod_low <= (i == 1);
      @(posedge pclk);
      dbg_tx_valid <= 1'b0;
      n = 0;
      n_low = 0;
      n_hi = 0;
      got_v = 1'b0;
      got_b = 1'bx;
      repeat (80) begin
        @(posedge pclk);
        n += int'(dbg_busy === 1'b1);
        n_low += int'(debug_pin_oe === 1'b1 && debug_pin_out === 1'b0);
        n_hi += int'(debug_pin_oe === 1'b1 && debug_pin_out === 1'b1);
        if (dbg_rx_valid === 1'b1) begin got_v = 1'b1; got_b = dbg_rx_bit; end
      end
      `CHK(n inside {[16*(i+1)-2:16*(i+1)+2]}, 1'b1)
      `CHK(got_v, 1'b1)
      `CHK(got_b, (i == 0))
      `CHK(n_low, int'(i == 1 ? DBG_ZERO_LOW : DBG_ONE_LOW) * (i + 1))
      `CHK(n_hi, i + 1)
      pod_low <= 1'b0;
    end
    $display("test debug done");
  endtask
  initial begin
    num_errors = 0;
    n_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {wdog_reset_req, lvd_reset_req, ilop_reset_req, dbg_tx_valid, dbg_tx_bit} = '0;
    {irq_pin_in, ext_hold, keypad_rising_sens, port_pin_in} = '0;
    alt1 = '0;
    alt2 = '0;
    pod_low = 1'b1;
    cyc(3);
    presetn <= 1'b1;
    t_power_on();
    t_internal();
    t_held();
    t_external();
    t_pins();
    t_irq();
    t_debug();
    results();
  end
  initial begin
    #200000;
    num_errors++;
    $display("Error at %0t: timeout", $time);
    results();
  end
endmodule
`default_nettype wire
